//--- design/dsiho_core.sv
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - Decrement memory word into ACC and memory
// - Nonzero-skip decrement: result nonzero, PC plus two
// - Zero-skip decrement: result zero, PC plus two
// - Bit above address selects zero/nonzero skip
// - Interrupt disable clears global enable
// - Interrupt enable sets global enable
// - Hold entered; accepted interrupt leaves it
// - Enabled wake condition also leaves hold
// - Return after hold-waking interrupt re-enters hold
module dsiho_core
  import dsiho_pkg::*;
(
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // APB slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic      [31:0]                   prdata,
  output logic                               pready,
  output logic                               pslverr,
  // Instruction path
  input  wire logic                          instr_valid,
  input  wire logic [dsiho_pkg::INSTR_W-1:0] instr_word,
  input  wire logic [dsiho_pkg::DATA_W-1:0]  ram_rdata,
  output logic                               ram_we,
  output logic      [dsiho_pkg::RADDR_W-1:0] ram_waddr,
  output logic      [dsiho_pkg::DATA_W-1:0]  ram_wdata,
  output logic      [dsiho_pkg::DATA_W-1:0]  acc,
  output logic                               carry_flag,
  output logic                               zero_flag,
  output logic      [dsiho_pkg::STEP_W-1:0]  pc_step,
  // Interrupt and power
  input  wire logic                          irq_pending,
  input  wire logic [dsiho_pkg::WAKE_W-1:0]  wake_events,
  output logic                               irq_take,
  output logic                               gie,
  output logic                               hold_active
);

  import dsiho_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  dsiho_state_t               state_q;
  dsiho_state_t               state_d;
  dsiho_op_t                  op;
  logic [DATA_W-1:0]          dec_res;
  logic                       dec_zero;
  logic                       dec_borrow;
  logic                       exec;
  logic                       take;
  logic                       wake;
  logic [WAKE_W-1:0]          hold_release_enable_flags_q;
  logic                       apb_acc;
  logic                       apb_wr;
  logic                       apb_rd;
  logic [31:0]                status_word;

  // ==========================================================
  // Functions
  // ==========================================================
  // Classify an instruction word
  function automatic dsiho_op_t decode_op(input logic [INSTR_W-1:0] w);
    dsiho_op_t r;
    r = DSIHO_OP_NONE;
    if (w[15:7] == OP_DEC_HI)
    begin
      r = DSIHO_OP_DEC;
    end
    else if (w[15:7] == OP_DECREMENT_SKIP_ZERO_OP_HI)
    begin
      r = DSIHO_OP_DECREMENT_SKIP_ZERO_OP;
    end
    else if (w[15:7] == OP_DECREMENT_SKIP_NONZERO_OP_HI)
    begin
      r = DSIHO_OP_DECREMENT_SKIP_NONZERO_OP;
    end
    else if (w == OP_INTERRUPT_DISABLE_OP)
    begin
      r = DSIHO_OP_DIS;
    end
    else if (w == OP_EN_INT)
    begin
      r = DSIHO_OP_EN;
    end
    else if (w == OP_HOLD)
    begin
      r = DSIHO_OP_HOLD;
    end
    else if (w == OP_RTN)
    begin
      r = DSIHO_OP_RTN;
    end
    return r;
  endfunction

  // True for the three decrementing forms
  function automatic logic is_dec(input dsiho_op_t o);
    return (o == DSIHO_OP_DEC) || (o == DSIHO_OP_DECREMENT_SKIP_ZERO_OP) || (o == DSIHO_OP_DECREMENT_SKIP_NONZERO_OP);
  endfunction

  // ==========================================================
  // Decode and arithmetic
  // ==========================================================
  // Instructions are refused while the core is held
  assign exec       = instr_valid && (state_q != DSIHO_HOLD);
  assign op         = decode_op(instr_word);
  assign dec_res    = ram_rdata - 4'h1;
  assign dec_zero   = (dec_res == 4'h0);
  assign dec_borrow = (ram_rdata == 4'h0);

  // Interrupt acceptance and wake detection
  assign take = gie && irq_pending && (instr_valid || (state_q == DSIHO_HOLD));
  assign wake = |(wake_events & hold_release_enable_flags_q);

  // ==========================================================
  // Power state
  // ==========================================================
  // Next power state
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      DSIHO_RUN:
      begin
        if (exec && (op == DSIHO_OP_HOLD))
        begin
          state_d = DSIHO_HOLD;
        end
      end
      DSIHO_HOLD:
      begin
        if (take)
        begin
          state_d = DSIHO_ISR;
        end
        else if (wake)
        begin
          state_d = DSIHO_RUN;
        end
      end
      DSIHO_ISR:
      begin
        if (exec && ((op == DSIHO_OP_RTN) || (op == DSIHO_OP_HOLD)))
        begin
          state_d = DSIHO_HOLD;
        end
      end
      default:
      begin
        state_d = DSIHO_RUN;
      end
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= DSIHO_RUN;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // Outputs of the power state
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_active <= 1'b0;
      irq_take    <= 1'b0;
    end
    else
    begin
      hold_active <= (state_d == DSIHO_HOLD);
      irq_take    <= take;
    end
  end

  // ==========================================================
  // Global interrupt enable
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gie <= 1'b0;
    end
    else if (exec && (op == DSIHO_OP_DIS))
    begin
      gie <= 1'b0;
    end
    else if (exec && (op == DSIHO_OP_EN))
    begin
      gie <= 1'b1;
    end
  end

  // ==========================================================
  // Accumulator, flags and memory write-back
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc        <= 4'h0;
      carry_flag <= 1'b0;
      zero_flag  <= 1'b0;
    end
    else if (exec && is_dec(op))
    begin
      acc        <= dec_res;
      carry_flag <= ~dec_borrow;
      zero_flag  <= dec_zero;
    end
  end

  // One-cycle memory write of the decremented word
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ram_we    <= 1'b0;
      ram_waddr <= 7'h00;
      ram_wdata <= 4'h0;
    end
    else
    begin
      ram_we <= exec && is_dec(op);
      if (exec && is_dec(op))
      begin
        ram_waddr <= instr_word[RADDR_W-1:0];
        ram_wdata <= dec_res;
      end
    end
  end

  // ==========================================================
  // Program counter step
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_step <= PC_STEP_NONE;
    end
    else if (!exec)
    begin
      pc_step <= PC_STEP_NONE;
    end
    else if ((op == DSIHO_OP_DECREMENT_SKIP_ZERO_OP) && dec_zero)
    begin
      pc_step <= PC_STEP_TWO;
    end
    else if ((op == DSIHO_OP_DECREMENT_SKIP_NONZERO_OP) && !dec_zero)
    begin
      pc_step <= PC_STEP_TWO;
    end
    else
    begin
      pc_step <= PC_STEP_ONE;
    end
  end

  // ==========================================================
  // APB slave, one wait state
  // ==========================================================
  assign apb_acc = psel && penable && !pready;
  assign apb_wr  = psel && penable && pready && pwrite;
  assign apb_rd  = apb_acc && !pwrite;

  // Status view of the core
  always_comb
  begin
    status_word = RDATA_ZERO;
    status_word[ST_ACC_LSB +: DATA_W] = acc;
    status_word[ST_CF_BIT]   = carry_flag;
    status_word[ST_ZF_BIT]   = zero_flag;
    status_word[ST_GIE_BIT]  = gie;
    status_word[ST_HOLD_BIT] = hold_active;
    status_word[ST_RES_BIT]  = (state_q == DSIHO_ISR);     // Entered from hold
    status_word[ST_ISR_BIT]  = (state_q == DSIHO_ISR);
  end

  // Handshake and read data
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RDATA_ZERO;
    end
    else
    begin
      pready  <= apb_acc;
      pslverr <= apb_acc && (paddr != REG_WAKE_CTRL) && (paddr != REG_STATUS);
      if (apb_rd && (paddr == REG_WAKE_CTRL))
      begin
        prdata <= {28'h0000000, hold_release_enable_flags_q};
      end
      else if (apb_rd && (paddr == REG_STATUS))
      begin
        prdata <= status_word;
      end
      else
      begin
        prdata <= RDATA_ZERO;
      end
    end
  end

  // Wake enable register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hold_release_enable_flags_q <= WAKE_CTRL_RST;
    end
    else if (apb_wr && (paddr == REG_WAKE_CTRL))
    begin
      hold_release_enable_flags_q <= pwdata[WAKE_W-1:0];
    end
  end

endmodule

//--- design/dsiho_pkg.sv
package dsiho_pkg;

  // ==========================================================
  // Core widths
  // ==========================================================
  localparam int unsigned INSTR_W = 16;
  localparam int unsigned DATA_W  = 4;
  localparam int unsigned RADDR_W = 7;
  localparam int unsigned WAKE_W  = 4;
  localparam int unsigned STEP_W  = 2;

  // ==========================================================
  // Opcode patterns (upper nine bits above the address field)
  // ==========================================================
  localparam logic [8:0] OP_DEC_HI   = 9'h095;
  localparam logic [8:0] OP_DECREMENT_SKIP_ZERO_OP_HI  = 9'h090;
  localparam logic [8:0] OP_DECREMENT_SKIP_NONZERO_OP_HI = 9'h091;

  // Full-word codes of the operand-free instructions
  localparam logic [15:0] OP_INTERRUPT_DISABLE_OP = 16'h4C00;
  localparam logic [15:0] OP_EN_INT  = 16'h4C01;
  localparam logic [15:0] OP_HOLD    = 16'h4C02;
  localparam logic [15:0] OP_RTN     = 16'h4C03;

  // ==========================================================
  // Program counter steps
  // ==========================================================
  localparam logic [1:0] PC_STEP_NONE = 2'h0;
  localparam logic [1:0] PC_STEP_ONE  = 2'h1;
  localparam logic [1:0] PC_STEP_TWO  = 2'h2;

  // ==========================================================
  // APB register map (byte addresses)
  // ==========================================================
  localparam logic [7:0] REG_WAKE_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;

  // Status field positions
  localparam int unsigned ST_ACC_LSB = 0;
  localparam int unsigned ST_CF_BIT  = 4;
  localparam int unsigned ST_ZF_BIT  = 5;
  localparam int unsigned ST_GIE_BIT = 6;
  localparam int unsigned ST_HOLD_BIT = 7;
  localparam int unsigned ST_RES_BIT = 8;
  localparam int unsigned ST_ISR_BIT = 9;

  // Reset values
  localparam logic [3:0]  WAKE_CTRL_RST = 4'h0;
  localparam logic [31:0] RDATA_ZERO    = 32'h0000_0000;

  // ==========================================================
  // Decoded operation classes
  // ==========================================================
  typedef enum logic [2:0] {
    DSIHO_OP_NONE  = 3'b000,
    DSIHO_OP_DEC   = 3'b001,
    DSIHO_OP_DECREMENT_SKIP_ZERO_OP  = 3'b010,
    DSIHO_OP_DECREMENT_SKIP_NONZERO_OP = 3'b011,
    DSIHO_OP_DIS   = 3'b100,
    DSIHO_OP_EN    = 3'b101,
    DSIHO_OP_HOLD  = 3'b110,
    DSIHO_OP_RTN   = 3'b111
  } dsiho_op_t;

  // Power state of the core
  typedef enum logic [1:0] {
    DSIHO_RUN  = 2'b00,
    DSIHO_HOLD = 2'b01,
    DSIHO_ISR  = 2'b10
  } dsiho_state_t;

endpackage

//--- verification/dsiho_checker.sv
`timescale 1ns/1ps
module dsiho_checker
  import dsiho_pkg::*;
(
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic                          pready,
  input wire logic                          instr_valid,
  input wire logic [dsiho_pkg::INSTR_W-1:0] instr_word,
  input wire logic [dsiho_pkg::DATA_W-1:0]  ram_rdata,
  input wire logic                          ram_we,
  input wire logic [dsiho_pkg::DATA_W-1:0]  ram_wdata,
  input wire logic [dsiho_pkg::DATA_W-1:0]  acc,
  input wire logic                          carry_flag,
  input wire logic                          zero_flag,
  input wire logic [dsiho_pkg::STEP_W-1:0]  pc_step,
  input wire logic                          irq_pending,
  input wire logic [dsiho_pkg::WAKE_W-1:0]  wake_events,
  input wire logic                          irq_take,
  input wire logic                          gie,
  input wire logic                          hold_active
);
  // ==========================================================
  // Helpers
  // ==========================================================
  logic       go;
  logic [8:0] hi;
  // Instruction executes, no interrupt competing
  assign go = instr_valid && !hold_active && !(gie && irq_pending);
  assign hi = instr_word[15:7];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_dec_any;
    go && (hi == OP_DEC_HI || hi == OP_DECREMENT_SKIP_ZERO_OP_HI || hi == OP_DECREMENT_SKIP_NONZERO_OP_HI);
  endsequence
  sequence s_held_quiet;
    hold_active && !(gie && irq_pending) && wake_events == 4'h0;
  endsequence
  sequence s_apb_wait;
    psel && penable && !pready;
  endsequence
  // ==========================================================
  // Assertions
  // ==========================================================
  a_dec_result: assert property (go && hi == OP_DEC_HI |=> acc == $past(ram_rdata) - 4'h1
    && ram_we && ram_wdata == acc && pc_step == PC_STEP_ONE) else $error("decrement result");
  a_dec_flags: assert property (s_dec_any |=> carry_flag == ($past(ram_rdata) != 4'h0)
    && zero_flag == ($past(ram_rdata) == 4'h1)) else $error("decrement flags");
  a_zero_skip: assert property (go && hi == OP_DECREMENT_SKIP_ZERO_OP_HI |=> pc_step ==
    (($past(ram_rdata) == 4'h1) ? PC_STEP_TWO : PC_STEP_ONE)) else $error("zero skip step");
  a_nonzero_skip: assert property (go && hi == OP_DECREMENT_SKIP_NONZERO_OP_HI |=> pc_step ==
    (($past(ram_rdata) != 4'h1) ? PC_STEP_TWO : PC_STEP_ONE)) else $error("nonzero skip step");
  a_dis_gie: assert property (go && instr_word == OP_INTERRUPT_DISABLE_OP |=> !gie)
    else $error("disable left enable set");
  a_en_gie: assert property (go && instr_word == OP_EN_INT |=> gie)
    else $error("enable left enable clear");
  a_hold_entry: assert property (go && instr_word == OP_HOLD |=> hold_active)
    else $error("hold not entered");
  a_irq_release: assert property (hold_active && gie && irq_pending |=> irq_take
    && !hold_active) else $error("interrupt did not release hold");
  a_hold_stays: assert property (s_held_quiet |=> hold_active)
    else $error("hold left without cause");
  a_apb_answer: assert property (s_apb_wait |=> pready) else $error("no bus answer");
endmodule

bind dsiho_core dsiho_checker dsiho_checker_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .instr_valid(instr_valid),
  .instr_word(instr_word), .ram_rdata(ram_rdata), .ram_we(ram_we), .ram_wdata(ram_wdata),
  .acc(acc), .carry_flag(carry_flag), .zero_flag(zero_flag), .pc_step(pc_step),
  .irq_pending(irq_pending), .wake_events(wake_events), .irq_take(irq_take), .gie(gie),
  .hold_active(hold_active));

//--- verification/test_dsiho_core.sv
`timescale 1ns/1ps
module test_dsiho_core;
  import dsiho_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        instr_valid, ram_we, carry_flag, zero_flag, irq_pending, irq_take, gie;
  logic        hold_active;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] instr_word;
  logic [6:0]  ram_waddr;
  logic [3:0]  ram_rdata, ram_wdata, acc, wake_events, res;
  logic [1:0]  pc_step, exp_step;
  logic [8:0]  ops [3] = '{OP_DEC_HI, OP_DECREMENT_SKIP_ZERO_OP_HI, OP_DECREMENT_SKIP_NONZERO_OP_HI};
  int          failures = 0;
  int          compares = 0;
  int          cycles = 0;

  dsiho_core dsiho_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .instr_valid(instr_valid), .instr_word(instr_word),
    .ram_rdata(ram_rdata), .ram_we(ram_we), .ram_waddr(ram_waddr), .ram_wdata(ram_wdata),
    .acc(acc), .carry_flag(carry_flag), .zero_flag(zero_flag), .pc_step(pc_step),
    .irq_pending(irq_pending), .wake_events(wake_events), .irq_take(irq_take), .gie(gie),
    .hold_active(hold_active));

  // ==========================================================
  // Clock, timeout and tasks
  // ==========================================================
  always #50 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Counts: %0d compares, %0d failures", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One instruction; outputs looked at after the taking edge
  task automatic exec(input logic [15:0] w, input logic [3:0] r);
    @(posedge pclk);
    instr_word <= w;
    ram_rdata <= r;
    instr_valid <= 1'b1;
    @(posedge pclk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // ==========================================================
  // Tests
  // ==========================================================
  initial
  begin
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {instr_valid, instr_word, ram_rdata, irq_pending, wake_events} = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    check({gie, hold_active}, 0);
    apb(0, REG_WAKE_CTRL, 0);
    check(rd, WAKE_CTRL_RST);
    apb(0, 8'h08, 0);
    check(err, 1);
    check(rd, 32'h0000_0000);
    apb(1, REG_WAKE_CTRL, 32'hFFFF_FFF5);
    apb(0, REG_WAKE_CTRL, 0);
    check(rd, 32'h0000_0005);
    $display("Test registers done");
    for (int k = 0; k < 3; k++)
      for (int v = 0; v < 16; v++)
      begin
        res = v[3:0] - 4'h1;
        exp_step = ((k == 1 && res == 4'h0) || (k == 2 && res != 4'h0)) ? 2'h2 : 2'h1;
        exec({ops[k], 7'h2A}, v[3:0]);
        check({acc, ram_wdata, ram_waddr, ram_we}, {res, res, 7'h2A, 1'b1});
        check({carry_flag, zero_flag}, {v != 0, res == 4'h0});
        check(pc_step, exp_step);
      end
    apb(0, REG_STATUS, 0);
    check(rd, 32'h0000_001E);
    $display("Test decrement done");
    exec(OP_EN_INT, 0);
    check(gie, 1);
    exec(OP_INTERRUPT_DISABLE_OP, 0);
    check(gie, 0);
    exec(OP_EN_INT, 0);
    exec(OP_HOLD, 0);
    check(hold_active, 1);
    exec({OP_DEC_HI, 7'h01}, 4'h5);
    check({pc_step, acc}, 6'h0E);
    apb(0, REG_STATUS, 0);
    check(rd, 32'h0000_00DE);
    @(posedge pclk);
    irq_pending <= 1'b1;
    @(posedge pclk);
    irq_pending <= 1'b0;
    #1;
    check({irq_take, hold_active}, 2'b10);
    apb(0, REG_STATUS, 0);
    check(rd, 32'h0000_035E);
    exec(OP_RTN, 0);
    check(hold_active, 1);
    $display("Test interrupt done");
    @(posedge pclk);
    wake_events <= 4'h2;
    repeat (3) @(posedge pclk);
    #1;
    check(hold_active, 1);
    @(posedge pclk);
    wake_events <= 4'h4;
    @(posedge pclk);
    #1;
    check(hold_active, 0);
    exec(OP_RTN, 0);
    check({hold_active, pc_step}, 3'b001);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    check({gie, hold_active}, 0);
    $display("Test wake and reset done");
    test_done();
  end
endmodule
